// ### hdl/rtcc_pkg.sv
package rtcc_pkg;
  localparam int unsigned CNT_WIDTH      = 40;
  localparam int unsigned PRESC_WIDTH    = 7;
  localparam logic [6:0]  PRESC_RISE     = 7'h3f;   // Count before the prescaled rising edge
  localparam int unsigned SYNC_STAGES    = 2;

  // Byte addresses on the configuration port
  localparam logic [7:0]  ADDR_CNT_LO    = 8'h40;
  localparam logic [7:0]  ADDR_CNT_HI    = 8'h44;
  localparam logic [7:0]  ADDR_MATCH_LO  = 8'h48;
  localparam logic [7:0]  ADDR_MATCH_HI  = 8'h4c;
  localparam logic [7:0]  ADDR_HIT_LO    = 8'h50;
  localparam logic [7:0]  ADDR_HIT_HI    = 8'h54;
  localparam logic [7:0]  ADDR_CTRL      = 8'h58;
  localparam logic [7:0]  READ_NONE      = 8'h00;

  // Control/status field positions
  localparam int unsigned BIT_SOFT_RESET = 7;
  localparam int unsigned BIT_COUNT_RUN  = 6;
  localparam int unsigned BIT_WAKE       = 5;
  localparam int unsigned BIT_MODE_HI    = 4;
  localparam int unsigned BIT_MODE_LO    = 3;
  localparam int unsigned BIT_CLR_HIT    = 2;
  localparam int unsigned BIT_CLEAR_N    = 1;
  localparam int unsigned BIT_OWNERSHIP  = 0;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
endpackage

// ### hdl/rtcc_core.sv
module rtcc_core
  import rtcc_pkg::*;
#(
  parameter int unsigned WIDTH = CNT_WIDTH
) (
  input  wire logic       CORE_CLK_I,
  input  wire logic       NRST_I,
  input  wire logic [7:0] CFG_ADDR_I,
  input  wire logic [7:0] CFG_WDATA_I,
  input  wire logic       CFG_WEN_I,
  input  wire logic       CFG_REN_I,
  input  wire logic       RTC_OSC_CLOCK_I,
  output logic      [7:0] CFG_RDATA_O,
  output logic            MATCH_OUT_O,
  output logic      [1:0] OSC_MODE_OUT_O,
  output logic            OSC_SELECT_OUT_O
);

  // Byte i of a 40-bit value
  function automatic logic [7:0] get_byte(input logic [WIDTH-1:0] v, input logic [2:0] idx);
    logic [WIDTH-1:0] sh;
    sh = v >> {idx, 3'b000};
    return sh[7:0];
  endfunction

  // Replace byte i of a 40-bit value
  function automatic logic [WIDTH-1:0] put_byte(input logic [WIDTH-1:0] v, input logic [2:0] idx,
                                                input logic [7:0] b);
    logic [WIDTH-1:0] mask;
    logic [WIDTH-1:0] ins;
    mask = {{(WIDTH-8){1'b0}}, 8'hff} << {idx, 3'b000};
    ins  = {{(WIDTH-8){1'b0}}, b} << {idx, 3'b000};
    return (v & ~mask) | ins;
  endfunction

  // Address falls inside an inclusive byte range
  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // Byte position of an address within its set
  function automatic logic [2:0] byte_index(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    return d[2:0];
  endfunction

  logic [7:0]             ctrl;
  logic [SYNC_STAGES-1:0] tk_sync;
  logic [1:0]             osc_sync;
  logic                   osc_prev;
  logic [PRESC_WIDTH-1:0] presc;
  logic [WIDTH-1:0]       counter;
  logic [WIDTH-1:0]       match_reg;
  logic [WIDTH-1:0]       cnt_capture;
  logic [WIDTH-1:0]       match_capture;
  logic [PRESC_WIDTH-1:0] next_presc;
  logic [7:0]             rdata;

  wire logic             tk_raw_n;
  wire logic             tk_rst_n;
  wire logic             osc_edge;
  wire logic             run_ok;
  wire logic             presc_rise;
  wire logic             equal;
  wire logic             zero_cnt;
  wire logic             sel_cnt;
  wire logic             sel_match;
  wire logic             sel_hit;
  wire logic             sel_ctrl;
  wire logic [2:0]       cnt_idx;
  wire logic [2:0]       match_idx;
  wire logic [2:0]       hit_idx;
  wire logic             rd_cnt_lo;
  wire logic             rd_match_lo;
  wire logic             hit_clear;
  wire logic             wr_cnt;
  wire logic             wr_match;
  wire logic             wr_ctrl;
  wire logic [WIDTH-1:0] next_counter;
  wire logic [7:0]       next_rdata;

  // Raw timekeeping reset: supply invalid or soft reset bit
  assign tk_raw_n = NRST_I & ~ctrl[BIT_SOFT_RESET];
  assign tk_rst_n = tk_sync[SYNC_STAGES-1];

  // Control/status register; only the supply reset clears it, so soft reset survives itself
  // Soft reset stays set until software writes the bit back to zero
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ctrl <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= CFG_WDATA_I;
    end
  end

  // Reset bridge: asserts at once, releases on the second edge
  // Release is clean in the core clock, so no flop sees reset drop mid-cycle
  always_ff @(posedge CORE_CLK_I or negedge tk_raw_n) begin
    if (!tk_raw_n) begin
      tk_sync <= '0;
    end else begin
      tk_sync <= {tk_sync[SYNC_STAGES-2:0], 1'b1};
    end
  end

  // Oscillator input sampled in the core clock; rate must stay well below half the core clock
  // Each oscillator level must last more than one core cycle or edges are lost
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      osc_sync <= 2'b00;
      osc_prev <= 1'b0;
    end else begin
      osc_sync <= {osc_sync[0], RTC_OSC_CLOCK_I};
      osc_prev <= osc_sync[1];
    end
  end
  assign osc_edge = osc_sync[1] & ~osc_prev;

  // Prescaler runs only with both run and clear-release bits set
  assign run_ok     = ctrl[BIT_COUNT_RUN] & ctrl[BIT_CLEAR_N];
  assign presc_rise = osc_edge && (presc == PRESC_RISE);
  assign next_presc = PRESC_WIDTH'(presc + 1'b1);

  always_ff @(posedge CORE_CLK_I or negedge tk_rst_n) begin
    if (!tk_rst_n) begin
      presc <= '0;
    end else if (!run_ok) begin
      presc <= '0;
    end else if (osc_edge) begin
      presc <= next_presc;
    end
  end

  // Comparator and match output
  assign equal       = (counter == match_reg);
  assign zero_cnt    = (counter == '0);
  assign MATCH_OUT_O = equal & ctrl[BIT_WAKE];

  // Counter next value: self-clear on hit except at zero, else increment
  // A zero match would otherwise pin the counter at zero forever
  assign hit_clear    = ctrl[BIT_CLR_HIT] && equal && !zero_cnt;
  assign next_counter = hit_clear ? '0
                      : counter + 1'b1;

  // Address decode of the byte-wide configuration port
  assign sel_cnt     = in_range(CFG_ADDR_I, ADDR_CNT_LO, ADDR_CNT_HI);
  assign sel_match   = in_range(CFG_ADDR_I, ADDR_MATCH_LO, ADDR_MATCH_HI);
  assign sel_hit     = in_range(CFG_ADDR_I, ADDR_HIT_LO, ADDR_HIT_HI);
  assign sel_ctrl    = (CFG_ADDR_I == ADDR_CTRL);
  assign cnt_idx     = byte_index(CFG_ADDR_I, ADDR_CNT_LO);
  assign match_idx   = byte_index(CFG_ADDR_I, ADDR_MATCH_LO);
  assign hit_idx     = byte_index(CFG_ADDR_I, ADDR_HIT_LO);
  assign rd_cnt_lo   = CFG_REN_I && (CFG_ADDR_I == ADDR_CNT_LO);
  assign rd_match_lo = CFG_REN_I && (CFG_ADDR_I == ADDR_MATCH_LO);

  // Write strobes per target
  assign wr_cnt      = CFG_WEN_I && sel_cnt;
  assign wr_match    = CFG_WEN_I && sel_match;
  assign wr_ctrl     = CFG_WEN_I && sel_ctrl;

  // Counter: clear bit wins, then preload writes, then prescaled increments
  always_ff @(posedge CORE_CLK_I or negedge tk_rst_n) begin
    if (!tk_rst_n) begin
      counter <= '0;
    end else if (!ctrl[BIT_CLEAR_N]) begin
      counter <= '0;
    end else if (wr_cnt) begin
      counter <= put_byte(counter, cnt_idx, CFG_WDATA_I);
    end else if (presc_rise && ctrl[BIT_COUNT_RUN]) begin
      counter <= next_counter;
    end
  end

  // Match register bytes
  always_ff @(posedge CORE_CLK_I or negedge tk_rst_n) begin
    if (!tk_rst_n) begin
      match_reg <= '0;
    end else if (wr_match) begin
      match_reg <= put_byte(match_reg, match_idx, CFG_WDATA_I);
    end
  end

  // Captured copies; the low byte itself returns the same value sampled in the read cycle
  // The low-byte read is the request and its own edge the acknowledge, so the next read sees the copy
  always_ff @(posedge CORE_CLK_I or negedge tk_rst_n) begin
    if (!tk_rst_n) begin
      cnt_capture   <= '0;
      match_capture <= '0;
    end else begin
      if (rd_cnt_lo) begin
        cnt_capture <= counter;
      end
      if (rd_match_lo) begin
        match_capture <= match_reg;
      end
    end
  end

  // Read mux: count and match upper bytes come from the capture, so those sets stay coherent across reads; hit bytes are live
  // Upper bytes read with no fresh low-byte read return the older copy
  assign next_rdata = rd_cnt_lo   ? counter[7:0]
                    : rd_match_lo ? match_reg[7:0]
                    : sel_cnt     ? get_byte(cnt_capture, cnt_idx)
                    : sel_match   ? get_byte(match_capture, match_idx)
                    : sel_hit     ? get_byte(~(counter ^ match_reg), hit_idx)
                    : sel_ctrl    ? ctrl
                    : READ_NONE;

  // Registered read data, updated only on a read strobe
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata <= READ_NONE;
    end else if (CFG_REN_I) begin
      rdata <= next_rdata;
    end
  end
  assign CFG_RDATA_O = rdata;

  // Oscillator control straight from the control bits
  assign OSC_MODE_OUT_O   = ctrl[BIT_MODE_HI:BIT_MODE_LO];
  assign OSC_SELECT_OUT_O = ctrl[BIT_OWNERSHIP];

endmodule // rtcc_core

// ### testbench/rtcc_core_sva.sv
module rtcc_core_sva
  import rtcc_pkg::*;
(
  input wire logic       CORE_CLK_I,
  input wire logic       NRST_I,
  input wire logic [7:0] CFG_ADDR_I,
  input wire logic [7:0] CFG_WDATA_I,
  input wire logic       CFG_WEN_I,
  input wire logic       CFG_REN_I,
  input wire logic       RTC_OSC_CLOCK_I,
  input wire logic [7:0] CFG_RDATA_O,
  input wire logic       MATCH_OUT_O,
  input wire logic [1:0] OSC_MODE_OUT_O,
  input wire logic       OSC_SELECT_OUT_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);
  logic [7:0] ctrl_sh;
  wire        wr_ctrl = CFG_WEN_I && CFG_ADDR_I == ADDR_CTRL;
  wire        mapped  = CFG_ADDR_I inside {[ADDR_CNT_LO:ADDR_CNT_HI], [ADDR_MATCH_LO:ADDR_MATCH_HI],
                                           [ADDR_HIT_LO:ADDR_HIT_HI], ADDR_CTRL};
  // Shadow control value; soft reset must not touch it
  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
    if (!NRST_I) ctrl_sh <= CTRL_RESET;
    else if (wr_ctrl) ctrl_sh <= CFG_WDATA_I;

  property p_mode; wr_ctrl |=> OSC_MODE_OUT_O == $past(CFG_WDATA_I[4:3]); endproperty
  a_mode: assert property (p_mode) else $error("mode pair wrong after control write");
  property p_sel; wr_ctrl |=> OSC_SELECT_OUT_O == $past(CFG_WDATA_I[0]); endproperty
  a_sel: assert property (p_sel) else $error("select wrong after control write");
  property p_wake; !ctrl_sh[BIT_WAKE] |-> !MATCH_OUT_O; endproperty
  a_wake: assert property (p_wake) else $error("match high with wake bit clear");
  property p_pwr; $rose(NRST_I) |-> OSC_MODE_OUT_O == 2'h0 && !OSC_SELECT_OUT_O && !MATCH_OUT_O; endproperty
  a_pwr: assert property (p_pwr) else $error("outputs not zero after power reset");
  property p_unmap; CFG_REN_I && !mapped |=> CFG_RDATA_O == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_back; CFG_REN_I && CFG_ADDR_I == ADDR_CTRL |=> CFG_RDATA_O == $past(ctrl_sh); endproperty
  a_back: assert property (p_back) else $error("control read back wrong");
  property p_zero;
    CFG_REN_I && CFG_ADDR_I == ADDR_CNT_LO && !ctrl_sh[BIT_CLEAR_N] && !$past(ctrl_sh[BIT_CLEAR_N])
      |=> CFG_RDATA_O == 8'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("counter not zero while cleared");
  property p_bits; MATCH_OUT_O && CFG_REN_I && CFG_ADDR_I inside {[ADDR_HIT_LO:ADDR_HIT_HI]} |=> CFG_RDATA_O == 8'hff;
  endproperty
  a_bits: assert property (p_bits) else $error("match bits not all ones on match");
endmodule // rtcc_core_sva

bind rtcc_core rtcc_core_sva i_sva (.CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I), .CFG_ADDR_I(CFG_ADDR_I),
  .CFG_WDATA_I(CFG_WDATA_I), .CFG_WEN_I(CFG_WEN_I), .CFG_REN_I(CFG_REN_I), .RTC_OSC_CLOCK_I(RTC_OSC_CLOCK_I),
  .CFG_RDATA_O(CFG_RDATA_O), .MATCH_OUT_O(MATCH_OUT_O), .OSC_MODE_OUT_O(OSC_MODE_OUT_O),
  .OSC_SELECT_OUT_O(OSC_SELECT_OUT_O));

// ### testbench/rtcc_osc_model.sv
module rtcc_osc_model #(
  parameter realtime HALF = 20.0
) (
  output logic osc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Free-running source; half period spans four core cycles, above the sync minimum
  initial osc_o = 1'b0;
  always #HALF osc_o = ~osc_o;
endmodule // rtcc_osc_model

// ### testbench/rtc_control_and_capture_tb.sv
module rtc_control_and_capture_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rtcc_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, wen = 1'b0, ren = 1'b0, osc, match, sel;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
  logic [1:0]  mode;
  logic [31:0] seed = 32'h8511;
  logic [39:0] val;
  int          fail_count = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  rtcc_core i_dut (.CORE_CLK_I(clk), .NRST_I(nrst), .CFG_ADDR_I(addr), .CFG_WDATA_I(wdata), .CFG_WEN_I(wen),
    .CFG_REN_I(ren), .RTC_OSC_CLOCK_I(osc), .CFG_RDATA_O(rdata), .MATCH_OUT_O(match), .OSC_MODE_OUT_O(mode),
    .OSC_SELECT_OUT_O(sel));
  rtcc_osc_model i_osc (.osc_o(osc));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input string name, input logic [39:0] exp, input logic [39:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One strobe cycle per byte, then released after the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 {wen, addr, wdata} = {1'b1, a, d};
    @(posedge clk);
    #1 wen = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 {ren, addr} = {1'b1, a};
    @(posedge clk);
    #1 ren = 1'b0;
    check("read data", exp, rdata);
  endtask
  task automatic report_and_stop;
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Counts oscillator rises in core cycles, so a dead oscillator ends the run instead of hanging
  task automatic osc_edges(input int n);
    int   seen;
    logic prev;
    seen = 0;
    prev = osc;
    for (int c = 0; c < 16 * n && seen < n; c++) begin
      @(posedge clk);
      if (osc && !prev) seen++;
      prev = osc;
    end
    if (seen < n) begin
      check("osc edges", 40'(n), 40'(seen));
      report_and_stop();
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 nrst = 1'b1;
    rd(ADDR_CTRL, CTRL_RESET);
    // Random control values; pins follow the fields
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wr(ADDR_CTRL, seed[7:0]);
      check("mode pair", seed[4:3], mode);
      check("select", seed[0], sel);
      rd(ADDR_CTRL, seed[7:0]);
    end
    // Stopped before preload; low byte read first, upper bytes in reverse
    wr(ADDR_CTRL, 8'h02);
    repeat (4) @(posedge clk);
    for (int s = 0; s < 2; s++) begin
      seed = lfsr(seed);
      val = {seed[7:0], lfsr(seed)};
      for (int b = 0; b < 5; b++) wr(ADDR_CNT_LO + 8'(8 * s + b), val[8 * b +: 8]);
      rd(ADDR_CNT_LO + 8'(8 * s), val[7:0]);
      for (int b = 4; b > 0; b--) rd(ADDR_CNT_LO + 8'(8 * s + b), val[8 * b +: 8]);
    end
    rd(8'h47, 8'h00);
    wr(ADDR_CTRL, 8'h80);
    wr(ADDR_CTRL, 8'h00);
    repeat (4) @(posedge clk);
    rd(ADDR_MATCH_LO, 8'h00);
    rd(ADDR_CNT_LO, 8'h00);
    wr(ADDR_MATCH_LO, 8'h03);
    // Counting timed in oscillator edges; sync delay is a few core cycles
    wr(ADDR_CTRL, 8'h42);
    osc_edges(80);
    rd(ADDR_CNT_LO, 8'h01);
    osc_edges(128);
    rd(ADDR_CNT_LO, 8'h02);
    wr(ADDR_CTRL, 8'h02);
    osc_edges(200);
    rd(ADDR_CNT_LO, 8'h02);
    wr(ADDR_CTRL, 8'h66);
    osc_edges(80);
    check("match", 1'b1, match);
    rd(ADDR_HIT_LO, 8'hff);
    osc_edges(128);
    rd(ADDR_CNT_LO, 8'h00);
    check("match", 1'b0, match);
    // Counting goes on after the self-clear; then the clear bit zeroes a live count
    osc_edges(128);
    rd(ADDR_CNT_LO, 8'h01);
    wr(ADDR_CTRL, 8'h64);
    check("select", 1'b0, sel);
    rd(ADDR_CNT_LO, 8'h00);
    report_and_stop();
  end
endmodule // rtc_control_and_capture_tb
